// ===== hdl/strap_map.svh
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH

// four-level strap encoding as seen by the pad sense logic
`define LVL_LOW 2'h0
`define LVL_WEAK_LOW 2'h1
`define LVL_WEAK_HIGH 2'h2
`define LVL_HIGH 2'h3

// target addresses (8-bit, write form)
`define MAIN_ADDR_BASE 8'h40
`define SYNTH_ADDR_OFFSET 8'h08

// serial command codes
`define CMD_SYNTH 8'h07
`define CMD_WRITE 8'h03
`define CMD_READ 8'h01

// hardware mode numbers
`define HW_MODE_ZERO 5'h00
`define HW_MODE_LAST_MASTER 5'h07
`define HW_MODE_FIRST_TDM 5'h10

// clock ratios for mode 0
`define FRAME_DIV_MODE0 11'h080
`define BIT_DIV_MODE0 11'h002

`endif

// ===== hdl/strap_pkg.sv
package strap_pkg;
    typedef enum logic [3:0] {
        CTRL_I2C = 4'h1,
        CTRL_SPI = 4'h2,
        CTRL_HW_LOW = 4'h4,
        CTRL_HW_HIGH = 4'h8
    } ctrl_mode_t;

    typedef enum logic [2:0] {
        CAP_IDLE = 3'h1,
        CAP_ARMED = 3'h2,
        CAP_HELD = 3'h4
    } cap_state_t;

    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_SYN = 2'h1,
        CMD_WR = 2'h2,
        CMD_RD = 2'h3
    } spi_cmd_t;
endpackage

// ===== hdl/level_decode.sv
`timescale 1ns/1ns
`include "strap_map.svh"

// turns a sensed strap level into drive strength and logic value
module level_decode (
    // sensed level
    input wire logic [1:0] level,
    // decoded view
    output logic is_weak,
    output logic is_high
);
    always_comb begin
        is_weak = (level == `LVL_WEAK_LOW) || (level == `LVL_WEAK_HIGH);
        is_high = (level == `LVL_WEAK_HIGH) || (level == `LVL_HIGH);
    end
endmodule

// ===== hdl/strap_mode_decoder.sv
`timescale 1ns/1ns
`include "strap_map.svh"

// ==========================================================
// Summary of operation
// [RULE1] control pin: i2c, spi, or hardware straps
// [RULE2] shared serial pins follow control decode
// [RULE3] i2c main address plus synth at +8
// [RULE4] spi first byte: 7 synth, 3 write, 1 read
// [RULE5] hardware mode configures only from straps
// [RULE6] strap bits 0 and 1 two-level only
// [RULE7] board sets straps while enable low
// [RULE8] input strap selects analog/pdm and pcm/spdif
// [RULE9] modes 16-30: no spdif, no pdm
// [RULE10] spdif only in master modes 0-7
// [RULE11] gp pin3 outputs audio data, format by strap
// [RULE12] analog: gp5 dc block, gp4 unused
// [RULE13] pdm: gp4 data in, gp5 clock out
// [RULE14] mute strap: mute and master clock select
// [RULE15] mode 0: master, fs=mclk/128, bck=mclk/2
// [RULE16] one output format at a time
// [RULE17] keep mute until enable raised
// [RULE18] capture straps on enable rise, hold
module strap_mode_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // chip enable and sensed strap levels
    input wire logic chip_enable,
    input wire logic [1:0] ctrl_select_level,
    input wire logic strap_bit0,
    input wire logic strap_bit1,
    input wire logic [1:0] strap_bit2_level,
    input wire logic [1:0] input_select_strap,
    input wire logic [1:0] mute_clock_level,
    // live pins used after capture
    input wire logic gp_pin4,
    input wire logic gp_pin5,
    input wire logic spi_first_byte_valid,
    input wire logic [7:0] spi_first_byte,
    // control port selection
    output logic config_valid,
    output logic sel_i2c,
    output logic sel_spi,
    output logic sel_hw,
    output logic [7:0] i2c_main_addr,
    output logic [7:0] i2c_synth_addr,
    output logic [1:0] spi_command,
    // hardware configuration
    output logic [4:0] hw_mode,
    output logic hw_mode_supported,
    output logic master_mode,
    output logic [10:0] frame_rate_div,
    output logic [10:0] bit_clock_rate_div,
    output logic pdm_input,
    output logic spdif_out,
    output logic pcm_out,
    output logic mute,
    output logic mclk_high_freq,
    output logic dc_block_enable,
    output logic pdm_data_in,
    // pin directions
    output logic gp_pin3_oe,
    output logic gp_pin5_oe,
    output logic mic_clock_out_sel
);
    strap_pkg::cap_state_t state_reg, state_next;
    logic [1:0] ctrl_reg, ctrl_next;
    logic b0_reg, b0_next, b1_reg, b1_next;
    logic [1:0] b2_reg, b2_next, in_reg, in_next, mc_reg, mc_next;
    logic in_weak, in_high, mc_weak, mc_high, b2_weak, b2_high;
    logic [1:0] cmd_reg, cmd_next;
    logic live_pdm, live_hw;
    logic [4:0] mode_w;

    // i2c main address from the two address strap levels
    function automatic logic [7:0] main_addr(input logic target_addr_strap1_high, input logic target_addr_strap0_high);
        main_addr = `MAIN_ADDR_BASE | {5'h00, target_addr_strap1_high, target_addr_strap0_high, 1'b0};
    endfunction

    // ==========================================================
    // strap capture
    always_comb begin
        state_next = state_reg;
        ctrl_next = ctrl_reg;
        b0_next = b0_reg;
        b1_next = b1_reg;
        b2_next = b2_reg;
        in_next = in_reg;
        mc_next = mc_reg;
        case (state_reg)
            strap_pkg::CAP_IDLE: begin
                if (!chip_enable) begin
                    state_next = strap_pkg::CAP_ARMED;
                end
            end
            strap_pkg::CAP_ARMED: begin
                // straps are trusted only once enable rises [RULE7]
                if (chip_enable) begin
                    state_next = strap_pkg::CAP_HELD; // [RULE18]
                    ctrl_next = ctrl_select_level;
                    b0_next = strap_bit0; // [RULE6]
                    b1_next = strap_bit1; // [RULE6]
                    b2_next = strap_bit2_level;
                    in_next = input_select_strap;
                    mc_next = mute_clock_level;
                end
            end
            strap_pkg::CAP_HELD: begin
                if (!chip_enable) begin
                    state_next = strap_pkg::CAP_ARMED; // [RULE18]
                end
            end
            default: begin
                state_next = strap_pkg::CAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= strap_pkg::CAP_IDLE;
            ctrl_reg <= `LVL_LOW;
            b0_reg <= 1'b0;
            b1_reg <= 1'b0;
            b2_reg <= `LVL_LOW;
            in_reg <= `LVL_LOW;
            // mute held until configured [RULE17]
            mc_reg <= `LVL_LOW;
        end else begin
            state_reg <= state_next;
            ctrl_reg <= ctrl_next;
            b0_reg <= b0_next;
            b1_reg <= b1_next;
            b2_reg <= b2_next;
            in_reg <= in_next;
            mc_reg <= mc_next;
        end
    end

    level_decode u_in (.level(in_reg), .is_weak(in_weak), .is_high(in_high));
    level_decode u_mc (.level(mc_reg), .is_weak(mc_weak), .is_high(mc_high));
    level_decode u_b2 (.level(b2_reg), .is_weak(b2_weak), .is_high(b2_high));

    // ==========================================================
    // spi command latch, first byte only
    always_comb begin
        cmd_next = cmd_reg;
        if (state_reg != strap_pkg::CAP_HELD || ctrl_reg != `LVL_HIGH) begin
            cmd_next = strap_pkg::CMD_NONE;
        end else if (spi_first_byte_valid) begin
            case (spi_first_byte) // [RULE4]
                `CMD_SYNTH: cmd_next = strap_pkg::CMD_SYN;
                `CMD_WRITE: cmd_next = strap_pkg::CMD_WR;
                `CMD_READ: cmd_next = strap_pkg::CMD_RD;
                default: cmd_next = strap_pkg::CMD_NONE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= strap_pkg::CMD_NONE;
        end else begin
            cmd_reg <= cmd_next;
        end
    end

    // ==========================================================
    // mode decode; the mode number follows the strap table rows
    assign live_hw = (state_reg == strap_pkg::CAP_HELD)
        && (ctrl_reg == `LVL_WEAK_LOW || ctrl_reg == `LVL_WEAK_HIGH); // [RULE1] [RULE5]
    // input select is not part of the number: it only picks source and format
    assign mode_w = {ctrl_reg == `LVL_WEAK_HIGH, b2_reg, b1_reg, b0_reg}; // [RULE15]
    // pdm only with modes 0-15 and input strap high side [RULE8] [RULE9]
    assign live_pdm = live_hw && in_high && (mode_w < `HW_MODE_FIRST_TDM);

    // ==========================================================
    // output registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_valid <= 1'b0;
            sel_i2c <= 1'b0;
            sel_spi <= 1'b0;
            sel_hw <= 1'b0;
            i2c_main_addr <= `MAIN_ADDR_BASE;
            i2c_synth_addr <= `MAIN_ADDR_BASE + `SYNTH_ADDR_OFFSET;
            spi_command <= strap_pkg::CMD_NONE;
            hw_mode <= `HW_MODE_ZERO;
            hw_mode_supported <= 1'b0;
            master_mode <= 1'b0;
            frame_rate_div <= `FRAME_DIV_MODE0;
            bit_clock_rate_div <= `BIT_DIV_MODE0;
            pdm_input <= 1'b0;
            spdif_out <= 1'b0;
            pcm_out <= 1'b0;
            mute <= 1'b1;
            mclk_high_freq <= 1'b0;
            dc_block_enable <= 1'b0;
            pdm_data_in <= 1'b0;
            gp_pin3_oe <= 1'b0;
            gp_pin5_oe <= 1'b0;
            mic_clock_out_sel <= 1'b0;
        end else begin
            config_valid <= state_reg == strap_pkg::CAP_HELD;
            sel_i2c <= (state_reg == strap_pkg::CAP_HELD) && ctrl_reg == `LVL_LOW; // [RULE1]
            sel_spi <= (state_reg == strap_pkg::CAP_HELD) && ctrl_reg == `LVL_HIGH; // [RULE2]
            sel_hw <= live_hw; // [RULE2]
            // address straps share the bit2 and mute pins; bit1 is scl [RULE3]
            i2c_main_addr <= main_addr(b2_high, mc_high);
            i2c_synth_addr <= main_addr(b2_high, mc_high) + `SYNTH_ADDR_OFFSET; // [RULE3]
            spi_command <= cmd_reg;
            hw_mode <= mode_w;
            // only mode 0 is built; control must be weak-low [RULE15]
            hw_mode_supported <= live_hw && ctrl_reg == `LVL_WEAK_LOW
                && mode_w == `HW_MODE_ZERO && !b2_weak;
            master_mode <= live_hw && mode_w <= `HW_MODE_LAST_MASTER;
            frame_rate_div <= `FRAME_DIV_MODE0; // [RULE15]
            bit_clock_rate_div <= `BIT_DIV_MODE0; // [RULE15]
            pdm_input <= live_pdm; // [RULE8]
            // spdif on weak input strap, master modes only [RULE10] [RULE11]
            spdif_out <= live_hw && in_weak && mode_w <= `HW_MODE_LAST_MASTER;
            // shared pin: exactly one format [RULE16]
            pcm_out <= live_hw && !(in_weak && mode_w <= `HW_MODE_LAST_MASTER);
            mute <= live_hw ? !mc_high : 1'b1; // [RULE14]
            mclk_high_freq <= live_hw && mc_weak; // [RULE14]
            dc_block_enable <= live_hw && !live_pdm && gp_pin5; // [RULE12]
            pdm_data_in <= live_pdm && gp_pin4; // [RULE13]
            gp_pin3_oe <= live_hw; // [RULE11]
            gp_pin5_oe <= live_pdm; // [RULE13]
            mic_clock_out_sel <= live_pdm; // [RULE13]
        end
    end
endmodule

// ===== verif/strap_checker_assertions.sv
`timescale 1ns/1ns
// ==========================================
// decoder output checks
module strap_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // live inputs
    input wire logic chip_enable,
    input wire logic spi_first_byte_valid,
    input wire logic [7:0] spi_first_byte,
    // decoded outputs
    input wire logic config_valid,
    input wire logic sel_i2c,
    input wire logic sel_spi,
    input wire logic sel_hw,
    input wire logic [7:0] i2c_main_addr,
    input wire logic [7:0] i2c_synth_addr,
    input wire logic [1:0] spi_command,
    input wire logic [4:0] hw_mode,
    input wire logic hw_mode_supported,
    input wire logic pdm_input,
    input wire logic spdif_out,
    input wire logic pcm_out,
    input wire logic mute
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_one_port;
        config_valid |-> $onehot({sel_i2c, sel_spi, sel_hw});
    endproperty
    a_one_port: assert property (p_one_port) else $error("port select not one-hot");
    property p_addr;
        (i2c_main_addr & 8'hF9) == 8'h40 && i2c_synth_addr == i2c_main_addr + 8'h08;
    endproperty
    a_addr: assert property (p_addr) else $error("target address pair wrong");
    property p_one_fmt;
        !(spdif_out && pcm_out);
    endproperty
    a_one_fmt: assert property (p_one_fmt) else $error("two output formats at once");
    property p_spdif_master;
        spdif_out |-> hw_mode <= 5'h07;
    endproperty
    a_spdif_master: assert property (p_spdif_master) else $error("spdif outside master");
    property p_tdm;
        sel_hw && hw_mode >= 5'h10 |-> !spdif_out && !pdm_input;
    endproperty
    a_tdm: assert property (p_tdm) else $error("tdm mode offers spdif or pdm");
    property p_supported;
        hw_mode_supported |-> sel_hw && hw_mode == 5'h00;
    endproperty
    a_supported: assert property (p_supported) else $error("supported flag off mode 0");
    // six cycles high covers capture plus the two-edge update
    sequence s_held;
        chip_enable [*6];
    endsequence
    property p_held;
        s_held |-> $stable(hw_mode) && $stable(mute) && $stable(i2c_main_addr);
    endproperty
    a_held: assert property (p_held) else $error("captured straps moved");
    sequence s_synth_cmd;
        sel_spi && spi_first_byte_valid && spi_first_byte == 8'h07;
    endsequence
    property p_spi_synth;
        s_synth_cmd |-> ##[1:3] spi_command == 2'h1;
    endproperty
    a_spi_synth: assert property (p_spi_synth) else $error("synth command not decoded");
endmodule

bind strap_mode_decoder strap_checker chk_u (.clk(clk), .rst_n(rst_n),
    .chip_enable(chip_enable), .spi_first_byte_valid(spi_first_byte_valid),
    .spi_first_byte(spi_first_byte), .config_valid(config_valid), .sel_i2c(sel_i2c),
    .sel_spi(sel_spi), .sel_hw(sel_hw), .i2c_main_addr(i2c_main_addr),
    .i2c_synth_addr(i2c_synth_addr), .spi_command(spi_command), .hw_mode(hw_mode),
    .hw_mode_supported(hw_mode_supported), .pdm_input(pdm_input),
    .spdif_out(spdif_out), .pcm_out(pcm_out), .mute(mute));

// ===== verif/board_model.sv
`timescale 1ns/1ns
// ==========================================
// board strap resistors and enable
module board_model (
    // clock
    input wire logic clk,
    // sensed strap levels
    output logic chip_enable,
    output logic [1:0] ctrl_select_level,
    output logic strap_bit0,
    output logic strap_bit1,
    output logic [1:0] strap_bit2_level,
    output logic [1:0] input_select_strap,
    output logic [1:0] mute_clock_level
);
    initial begin
        chip_enable = 1'b0;
        {ctrl_select_level, strap_bit0, strap_bit1, strap_bit2_level} = 6'h00;
        {input_select_strap, mute_clock_level} = 4'h0;
    end
    // levels settle with enable low; later changes wait for the next low phase
    task automatic power_up(input logic [1:0] ctl, input logic b0, input logic b1,
            input logic [1:0] b2, input logic [1:0] ins, input logic [1:0] mlv);
        @(posedge clk);
        chip_enable <= 1'b0;
        {ctrl_select_level, strap_bit0, strap_bit1, strap_bit2_level} <= {ctl, b0, b1, b2};
        input_select_strap <= ins;
        // mute level goes in on the same edge as the others; an unmute after the rise would not be captured
        mute_clock_level <= mlv;
        repeat (2) @(posedge clk);
        chip_enable <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
    endtask
    // strap moves while enable is high; the device must ignore them
    task automatic late_change(input logic b0, input logic [1:0] mlv);
        @(posedge clk);
        strap_bit0 <= b0;
        mute_clock_level <= mlv;
    endtask
    task automatic drop_enable;
        @(posedge clk);
        chip_enable <= 1'b0;
    endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ns
// ==========================================
// strap decoder testbench
module testbench;
    logic clk, rst_n, gp_pin4, gp_pin5, spi_first_byte_valid, chip_enable;
    logic strap_bit0, strap_bit1;
    logic [7:0] spi_first_byte;
    logic [1:0] ctrl_select_level, strap_bit2_level, input_select_strap, mute_clock_level;
    int err_total = 0;
    int comparisons = 0;
    board_model board_u (.clk(clk), .chip_enable(chip_enable),
        .ctrl_select_level(ctrl_select_level), .strap_bit0(strap_bit0),
        .strap_bit1(strap_bit1), .strap_bit2_level(strap_bit2_level),
        .input_select_strap(input_select_strap), .mute_clock_level(mute_clock_level));
    // outputs are read through the instance to keep the bench short
    strap_mode_decoder dut_u (.clk(clk), .rst_n(rst_n), .chip_enable(chip_enable),
        .ctrl_select_level(ctrl_select_level), .strap_bit0(strap_bit0),
        .strap_bit1(strap_bit1), .strap_bit2_level(strap_bit2_level),
        .input_select_strap(input_select_strap), .mute_clock_level(mute_clock_level),
        .gp_pin4(gp_pin4), .gp_pin5(gp_pin5), .spi_first_byte_valid(spi_first_byte_valid),
        .spi_first_byte(spi_first_byte), .config_valid(), .sel_i2c(), .sel_spi(),
        .sel_hw(), .i2c_main_addr(), .i2c_synth_addr(), .spi_command(), .hw_mode(),
        .hw_mode_supported(), .master_mode(), .frame_rate_div(), .bit_clock_rate_div(),
        .pdm_input(), .spdif_out(), .pcm_out(), .mute(), .mclk_high_freq(),
        .dc_block_enable(), .pdm_data_in(), .gp_pin3_oe(), .gp_pin5_oe(),
        .mic_clock_out_sel());
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic spi_send(input logic [7:0] b, input logic [1:0] exp);
        @(posedge clk);
        spi_first_byte_valid <= 1'b1;
        spi_first_byte <= b;
        @(posedge clk);
        spi_first_byte_valid <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(dut_u.spi_command, exp);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (2000) @(posedge clk);
        err_total++;
        test_done();
    end
    initial begin
        {rst_n, gp_pin4, gp_pin5, spi_first_byte_valid} = 4'h0;
        spi_first_byte = 8'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({dut_u.mute, dut_u.config_valid, dut_u.i2c_main_addr}, 10'h240);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            board_u.power_up(2'h0, 1'b0, 1'b0, {2{i[1]}}, 2'h0, {2{i[0]}});
            chk({dut_u.sel_i2c, dut_u.sel_spi, dut_u.sel_hw}, 3'h4);
            chk({dut_u.i2c_main_addr, dut_u.i2c_synth_addr}, {8'h40 + 8'(i * 2), 8'h48 + 8'(i * 2)});
        end
        spi_send(8'h07, 2'h0);
        $display("test i2c done");
        board_u.power_up(2'h3, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0);
        chk({dut_u.sel_i2c, dut_u.sel_spi, dut_u.sel_hw}, 3'h2);
        spi_send(8'h07, 2'h1);
        spi_send(8'h03, 2'h2);
        spi_send(8'h01, 2'h3);
        $display("test spi done");
        for (int m = 0; m < 4; m++) begin
            board_u.power_up(2'h1, 1'b0, 1'b0, 2'h0, 2'h0, m[1:0]);
            chk({dut_u.sel_hw, dut_u.hw_mode_supported, dut_u.master_mode}, 3'h7);
            chk({dut_u.frame_rate_div, dut_u.bit_clock_rate_div}, {11'h080, 11'h002});
            chk({dut_u.pcm_out, dut_u.spdif_out, dut_u.pdm_input}, 3'h4);
            chk({dut_u.gp_pin3_oe, dut_u.gp_pin5_oe, dut_u.mic_clock_out_sel}, 3'h4);
            chk({dut_u.mute, dut_u.mclk_high_freq}, {!m[1], m[0] ^ m[1]});
        end
        board_u.late_change(1'b1, 2'h0);
        gp_pin5 <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk({dut_u.mute, dut_u.hw_mode}, 6'h00);
        chk(dut_u.dc_block_enable, 1'b1);
        @(posedge clk);
        gp_pin5 <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(dut_u.dc_block_enable, 1'b0);
        $display("test hardware mode 0 done");
        @(posedge clk);
        gp_pin4 <= 1'b1;
        gp_pin5 <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            board_u.power_up(2'h1, 1'b0, 1'b0, 2'h0, k[1:0], 2'h3);
            chk(dut_u.spdif_out, ^k[1:0]);
            chk(dut_u.pdm_input, k[1]);
            chk(dut_u.pcm_out, ~^k[1:0]);
            chk({dut_u.gp_pin5_oe, dut_u.mic_clock_out_sel}, {2{k[1]}});
            chk({dut_u.pdm_data_in, dut_u.dc_block_enable}, {k[1], !k[1]});
            chk(dut_u.hw_mode_supported, 1'b1);
        end
        $display("test input select done");
        board_u.power_up(2'h2, 1'b1, 1'b1, 2'h0, 2'h2, 2'h3);
        chk({dut_u.sel_hw, dut_u.hw_mode, dut_u.hw_mode_supported}, 7'h66);
        chk({dut_u.pcm_out, dut_u.spdif_out, dut_u.pdm_input}, 3'h4);
        chk(dut_u.master_mode, 1'b0);
        board_u.drop_enable();
        repeat (4) @(posedge clk);
        #1;
        chk({dut_u.config_valid, dut_u.hw_mode}, 6'h13);
        $display("test other straps done");
        test_done();
    end
endmodule
